// >>> logic/ild_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/100ps
module ild_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  ild_stream_if.snk in_s,
  ild_stream_if.src out_s
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ild_fifo_s;
  ild_fifo_s r, n;
  logic [W-1:0] mem [D];
  logic push, pop;

  assign in_s.ready = r.cnt != (AW+1)'(D);
  assign out_s.valid = r.cnt != '0;
  assign out_s.data = mem[r.rp];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    n = r;
    if (push) begin
      n.wp = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[r.wp] <= in_s.data;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    r.cnt <= (AW+1)'(D)) else $error("fifo count above depth");
  a_fifo_full_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (r.cnt == (AW+1)'(D) && !pop) |=> r.cnt == (AW+1)'(D)) else $error("full fifo took a byte");
endmodule // ild_fifo

// >>> logic/ild_host_port.sv
// ISA host-port front end for five logical devices: decode, PROGRAMMED_IO_ACCESS, DMA, IRQ routing.
// Assumes ISA strobes sampled synchronously to clock_i; config comes from pins.
`timescale 1ns/100ps
module ild_host_port #(
  parameter int INIT_CYC = ild_pkg::INIT_CYC,
  parameter int CFG_MIN_CYC = ild_pkg::CFG_MIN_CYC,
  parameter int CFG_MAX_CYC = ild_pkg::CFG_MAX_CYC,
  parameter int JOYSTICKS = ild_pkg::JOY_MAX,
  parameter int MIDI_DEPTH = ild_pkg::MIDI_DEPTH
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic host_reset_drive_i,
  input wire logic [15:0] sa_i,
  input wire logic aen_i,
  input wire logic ior_n_i,
  input wire logic iow_n_i,
  input wire logic [7:0] sd_i,
  output logic [7:0] sd_o,
  output logic sd_oe_o,
  input wire logic [2:0] dack_n_i,
  output logic [2:0] drq_o,
  output logic [6:0] irq_o,
  input wire logic dec16_i,
  input wire logic [4:0] ld_active_i,
  input wire logic [4:0][11:0] ld_base_i,
  input wire logic [4:0][6:0] ld_len_i,
  input wire logic [4:0][9:0] ld_alt_base_i,
  input wire logic [4:0][3:0] ld_alt_len_i,
  input wire logic [4:0][2:0] ld_irq_sel_i,
  input wire logic [5:0] irq_req_i,
  input wire logic dma_release_timing_bit_i,
  input wire logic [2:0][2:0] dma_ld_i,
  input wire logic [2:0] dma_start_i,
  input wire logic [2:0][2:0] dma_bytes_i,
  input wire logic [2:0][7:0] dma_rd_data_i,
  output logic [2:0] dma_wr_o,
  output logic [2:0] dma_rd_o,
  output logic [7:0] data_o,
  input wire logic [7:0] func_rd_data_i,
  output logic func_wr_o,
  output logic func_rd_o,
  output logic [2:0] func_ld_o,
  output logic [6:0] func_off_o,
  output logic func_alt_o,
  input wire logic [7:0] joy_i,
  output logic joy_fire_o,
  output logic [7:0] power_ctl_o,
  output logic [7:0] joy_rate_o,
  output logic [7:0] res_data_o,
  output logic res_data_stb_o,
  input wire logic cfg_mem_present_i,
  input wire logic cfg_load_done_i,
  output logic cfg_load_o,
  output logic cfg_timeout_o,
  output logic ready_o,
  output logic [7:0] midi_tx_data_o,
  output logic midi_tx_valid_o,
  input wire logic midi_tx_ready_i,
  input wire logic [7:0] midi_rx_data_i,
  input wire logic midi_rx_valid_i,
  output logic midi_rx_ready_o
);
  typedef struct packed {
    ild_pkg::ild_state_e st;
    logic [23:0] cnt;
    logic cfg_load;
    logic cfg_to;
    logic iow_q;
    logic ior_q;
    logic [2:0] dack_q;
    logic [7:0] wdat;
    logic sel_hit;
    logic sel_dma;
    logic [1:0] sel_ch;
    logic [2:0] sel_ld;
    logic [6:0] sel_off;
    logic sel_alt;
    logic [7:0] sd;
    logic sd_oe;
    logic [2:0] drq;
    logic [2:0][2:0] left;
    logic [7:0] pwr;
    logic [7:0] joy_rate;
    logic [7:0] res;
    logic res_stb;
    logic func_wr;
    logic func_rd;
    logic [7:0] fdat;
    logic [2:0] dma_wr;
    logic [2:0] dma_rd;
    logic [6:0] irq;
    logic joy_fire;
    logic tx_push;
    logic rx_pop;
  } ild_regs_s;

  localparam ild_regs_s REGS_RST = '{st: ild_pkg::ST_INIT, iow_q: 1'b1, ior_q: 1'b1, dack_q: 3'h7,
    pwr: ild_pkg::PWR_RST, joy_rate: ild_pkg::JOY_RATE_RST, default: '0};

  // -------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // -------------------------------------------------------------------
  // MIDI queues
  // -------------------------------------------------------------------
  ild_stream_if #(.W(8)) tx_in ();
  ild_stream_if #(.W(8)) tx_out ();
  ild_stream_if #(.W(8)) rx_in ();
  ild_stream_if #(.W(8)) rx_out ();
  ild_regs_s r, n;

  assign tx_in.data = r.fdat;
  assign tx_in.valid = r.tx_push;
  assign midi_tx_data_o = tx_out.data;
  assign midi_tx_valid_o = tx_out.valid;
  assign tx_out.ready = midi_tx_ready_i;
  assign rx_in.data = midi_rx_data_i;
  assign rx_in.valid = midi_rx_valid_i;
  assign midi_rx_ready_o = rx_in.ready;
  assign rx_out.ready = r.rx_pop;

  ild_fifo #(.W(8), .D(MIDI_DEPTH)) u_tx_fifo (
    .clk_i(clock_i), .rst_n_i(rst_n), .in_s(tx_in), .out_s(tx_out));
  ild_fifo #(.W(8), .D(MIDI_DEPTH)) u_rx_fifo (
    .clk_i(clock_i), .rst_n_i(rst_n), .in_s(rx_in), .out_s(rx_out));

  // -------------------------------------------------------------------
  // Address decode per logical device
  // -------------------------------------------------------------------
  logic up_ok;
  logic [4:0] hit_b, hit_a;
  logic [4:0][6:0] off_b;
  logic [4:0][2:0] off_a;
  assign up_ok = !dec16_i || sa_i[15:12] == 4'h0;

  for (genvar g = 0; g < ild_pkg::NUM_LD; g++) begin : g_dec
    logic [11:0] db;
    logic [9:0] da;
    logic [3:0] alen;
    assign db = sa_i[11:0] - ld_base_i[g];
    assign da = sa_i[9:0] - ld_alt_base_i[g];
    // An alternate range never spans more than eight locations.
    assign alen = (ld_alt_len_i[g] > ild_pkg::ALT_MAX_LEN) ? ild_pkg::ALT_MAX_LEN : ld_alt_len_i[g];
    assign hit_b[g] = ld_active_i[g] && up_ok && (ild_pkg::LD_DEC12[g] || sa_i[11:10] == 2'h0)
      && db < {5'h00, ld_len_i[g]};
    assign hit_a[g] = ld_active_i[g] && up_ok && sa_i[11:10] == 2'h0 && da < {6'h00, alen};
    assign off_b[g] = db[6:0];
    assign off_a[g] = da[2:0];
  end

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    logic iow_rise, ior_rise, stb_fall, hit, alt, pio_ok, dma_ok, dma_cyc, own_ok, ld0_req;
    logic [2:0] ld;
    logic [6:0] off;
    logic [1:0] ch;
    logic [7:0] joy_mask;
    iow_rise = !r.iow_q && iow_n_i;
    ior_rise = !r.ior_q && ior_n_i;
    stb_fall = r.iow_q && r.ior_q && !(iow_n_i && ior_n_i);
    hit = 1'b0;
    alt = 1'b0;
    ld = 3'h0;
    off = 7'h00;
    own_ok = 1'b0;
    ld0_req = 1'b0;
    for (int i = ild_pkg::NUM_LD - 1; i >= 0; i--) begin
      if (hit_b[i] || hit_a[i]) begin
        hit = 1'b1;
        ld = 3'(i);
        alt = !hit_b[i];
        off = hit_b[i] ? off_b[i] : {4'h0, off_a[i]};
      end
    end
    ch = !dack_n_i[0] ? 2'h0 : (!dack_n_i[1] ? 2'h1 : 2'h2);
    pio_ok = r.st == ild_pkg::ST_READY && hit && dack_n_i == 3'h7 && !aen_i;
    dma_cyc = r.st == ild_pkg::ST_READY && dack_n_i != 3'h7 && aen_i;
    dma_ok = dma_cyc && dma_ld_i[ch] < 3'h5 && ld_active_i[dma_ld_i[ch]];
    n = r;
    n.iow_q = iow_n_i;
    n.ior_q = ior_n_i;
    n.dack_q = dack_n_i;
    {n.res_stb, n.func_wr, n.func_rd, n.joy_fire, n.tx_push, n.rx_pop} = 6'h00;
    n.dma_wr = 3'h0;
    n.dma_rd = 3'h0;
    if (!iow_n_i) begin
      n.wdat = sd_i;
    end
    // Address and class are frozen at the strobe's fall; the bus may move before the rise.
    if (stb_fall) begin
      n.sel_hit = pio_ok;
      n.sel_dma = dma_ok;
      n.sel_ch = ch;
      n.sel_ld = ld;
      n.sel_off = off;
      n.sel_alt = alt;
    end
    joy_mask = (JOYSTICKS >= ild_pkg::JOY_MAX) ? 8'hff : 8'h33;
    n.sd_oe = !ior_n_i && !stb_fall && (r.sel_hit || r.sel_dma);
    if (r.sel_dma) begin
      n.sd = dma_rd_data_i[r.sel_ch];
    end else begin
      unique case (r.sel_ld)
        ild_pkg::LD_GAME: n.sd = joy_i & joy_mask;
        ild_pkg::LD_CTRL: n.sd = (r.sel_off == ild_pkg::CTRL_PWR_OFF) ? r.pwr :
          (r.sel_off == ild_pkg::CTRL_JOY_OFF) ? r.joy_rate : r.res;
        ild_pkg::LD_MIDI: n.sd = (r.sel_off == ild_pkg::MIDI_STAT_OFF) ?
          {!rx_out.valid, !tx_in.ready, 6'h00} : rx_out.data;
        default: n.sd = func_rd_data_i;
      endcase
    end
    if (iow_rise) begin
      n.fdat = r.wdat;
      if (r.sel_dma) begin
        n.dma_wr[r.sel_ch] = 1'b1;
      end else if (r.sel_hit) begin
        unique case (r.sel_ld)
          ild_pkg::LD_GAME: n.joy_fire = 1'b1;
          ild_pkg::LD_CTRL: begin
            if (r.sel_off == ild_pkg::CTRL_PWR_OFF) begin
              n.pwr = r.wdat;
            end else if (r.sel_off == ild_pkg::CTRL_JOY_OFF) begin
              n.joy_rate = r.wdat;
            end else if (r.sel_off == ild_pkg::CTRL_RES_OFF) begin
              n.res = r.wdat;
              n.res_stb = 1'b1;
            end
          end
          // A byte written while the queue is full is dropped; the status bit shows it.
          ild_pkg::LD_MIDI: n.tx_push = r.sel_off == ild_pkg::MIDI_DATA_OFF;
          default: n.func_wr = 1'b1;
        endcase
      end
    end
    if (ior_rise) begin
      if (r.sel_dma) begin
        n.dma_rd[r.sel_ch] = 1'b1;
      end else if (r.sel_hit) begin
        n.rx_pop = r.sel_ld == ild_pkg::LD_MIDI && r.sel_off == ild_pkg::MIDI_DATA_OFF && rx_out.valid;
        n.func_rd = r.sel_ld != ild_pkg::LD_MIDI && r.sel_ld != ild_pkg::LD_CTRL && r.sel_ld != ild_pkg::LD_GAME;
      end
    end
    // Each channel serves one owner; it starts only from its own dma_start_i bit while that owner is active.
    for (int c = 0; c < ild_pkg::NUM_DMA; c++) begin
      own_ok = r.st == ild_pkg::ST_READY && dma_ld_i[c] < 3'h5 && ld_active_i[dma_ld_i[c]];
      if (!own_ok) begin
        n.drq[c] = 1'b0;
        n.left[c] = 3'h0;
      end else if (!r.drq[c]) begin
        if (dma_start_i[c]) begin
          n.drq[c] = 1'b1;
          n.left[c] = (dma_bytes_i[c] == 3'h0) ? 3'h1 : dma_bytes_i[c];
        end
      end else if (dma_release_timing_bit_i && r.left[c] == 3'h1 && r.dack_q[c] && !dack_n_i[c]) begin
        n.drq[c] = 1'b0;
        n.left[c] = 3'h0;
      end else if (stb_fall && !dack_n_i[c] && aen_i) begin
        n.left[c] = r.left[c] - 3'h1;
        n.drq[c] = r.left[c] != 3'h1;
      end
    end
    ld0_req = irq_req_i[0] || irq_req_i[5];
    for (int p = 0; p < ild_pkg::NUM_IRQ; p++) begin
      n.irq[p] = 1'b0;
      for (int i = 0; i < ild_pkg::NUM_LD; i++) begin
        if (ld_active_i[i] && ld_irq_sel_i[i] == 3'(p) && (i == 0 ? ld0_req : irq_req_i[i])) begin
          n.irq[p] = r.st == ild_pkg::ST_READY;
        end
      end
    end
    unique case (r.st)
      ild_pkg::ST_INIT: begin
        n.cnt = r.cnt + 24'h1;
        if (r.cnt >= 24'(INIT_CYC - 1)) begin
          n.st = ild_pkg::ST_LOAD;
          n.cnt = 24'h0;
          n.cfg_load = 1'b1;
        end
      end
      ild_pkg::ST_LOAD: begin
        n.cnt = r.cnt + 24'h1;
        if (r.cnt >= 24'(CFG_MIN_CYC - 1) && (!cfg_mem_present_i || cfg_load_done_i)) begin
          n.st = ild_pkg::ST_READY;
          n.cfg_load = 1'b0;
        end else if (r.cnt >= 24'(CFG_MAX_CYC - 1)) begin
          n.st = ild_pkg::ST_READY;
          n.cfg_load = 1'b0;
          n.cfg_to = 1'b1;
        end
      end
      ild_pkg::ST_READY: n.cnt = r.cnt;
    endcase
    if (host_reset_drive_i) begin
      n = REGS_RST;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= REGS_RST;
    end else begin
      r <= n;
    end
  end

  assign sd_o = r.sd;
  assign sd_oe_o = r.sd_oe;
  assign drq_o = r.drq;
  assign irq_o = r.irq;
  assign dma_wr_o = r.dma_wr;
  assign dma_rd_o = r.dma_rd;
  assign data_o = r.fdat;
  assign func_wr_o = r.func_wr;
  assign func_rd_o = r.func_rd;
  assign func_ld_o = r.sel_ld;
  assign func_off_o = r.sel_off;
  assign func_alt_o = r.sel_alt;
  assign joy_fire_o = r.joy_fire;
  assign power_ctl_o = r.pwr;
  assign joy_rate_o = r.joy_rate;
  assign res_data_o = r.res;
  assign res_data_stb_o = r.res_stb;
  assign cfg_load_o = r.cfg_load;
  assign cfg_timeout_o = r.cfg_to;
  assign ready_o = r.st == ild_pkg::ST_READY;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  a_idle_quiet: assert property (r.st != ild_pkg::ST_READY |-> !sd_oe_o && drq_o == 3'h0 && irq_o == 7'h00)
    else $error("bus driven before ready");
  a_host_reset_init: assert property (host_reset_drive_i |=> r.st == ild_pkg::ST_INIT && r.cnt == 24'h0)
    else $error("host reset did not reinitialise");
  a_init_length: assert property ($rose(r.st == ild_pkg::ST_LOAD) |-> $past(r.cnt) == 24'(INIT_CYC - 1))
    else $error("init phase length wrong");
  a_load_min_time: assert property ($rose(ready_o) |-> $past(r.cnt) >= 24'(CFG_MIN_CYC - 1))
    else $error("config load too short");
  a_load_max_time: assert property (r.st == ild_pkg::ST_LOAD && r.cnt >= 24'(CFG_MAX_CYC - 1) |=> ready_o)
    else $error("config load overran");
  a_oe_needs_read: assert property (sd_oe_o |-> $past(!ior_n_i) && $past(!ior_n_i, 2))
    else $error("data driven without read strobe");
  a_pwr_write: assert property (!r.iow_q && iow_n_i && r.sel_hit && !r.sel_dma && r.sel_ld == ild_pkg::LD_CTRL
    && r.sel_off == ild_pkg::CTRL_PWR_OFF && !host_reset_drive_i |=> power_ctl_o == $past(r.wdat))
    else $error("control write lost");
  a_dma_no_pio: assert property (dma_wr_o != 3'h0 |-> !func_wr_o && !r.tx_push)
    else $error("dma cycle decoded as pio");
  // The drop is decided one edge before it shows, so ownership is compared over the two edges before it.
  a_drq_held: assert property ($fell(drq_o[0]) && $past(ld_active_i) == $past(ld_active_i, 2)
    && !$past(host_reset_drive_i) |-> $past(r.left[0]) == 3'h1)
    else $error("request dropped before last byte");
  a_drq_release: assert property (drq_o[0] && r.left[0] == 3'h1 && r.iow_q && r.ior_q && !iow_n_i && !dack_n_i[0]
    && aen_i && !host_reset_drive_i |=> !drq_o[0])
    else $error("request held past final strobe");
  a_irq_gated: assert property ($past(ld_active_i) == 5'h00 |-> irq_o == 7'h00)
    else $error("interrupt from inactive device");

  c_dma_done: cover property ($fell(drq_o[0]));
  c_midi_push: cover property (r.tx_push);
  c_load_timeout: cover property ($rose(cfg_timeout_o));
  c_ctrl_read: cover property (sd_oe_o && r.sel_ld == ild_pkg::LD_CTRL);
endmodule // ild_host_port

// >>> logic/ild_pkg.sv
// Constants shared by the ISA logical-device front end and its queues.
// Assumes a single 25 MHz system clock.
package ild_pkg;
  localparam int NUM_LD = 5;
  localparam int NUM_DMA = 3;
  localparam int NUM_IRQ = 7;
  localparam int CLK_HZ = 25000000;
  localparam int INIT_MS = 3;
  localparam int CFG_MIN_MS = 1;
  localparam int CFG_MAX_MS = 190;
  localparam int INIT_CYC = INIT_MS * (CLK_HZ / 1000);
  localparam int CFG_MIN_CYC = CFG_MIN_MS * (CLK_HZ / 1000);
  localparam int CFG_MAX_CYC = CFG_MAX_MS * (CLK_HZ / 1000);
  localparam int MIDI_DEPTH = 16;
  localparam int JOY_MAX = 2;
  localparam logic [4:0] LD_DEC12 = 5'h05;
  localparam logic [3:0] ALT_MAX_LEN = 4'h8;
  localparam logic [2:0] LD_GAME = 3'h1;
  localparam logic [2:0] LD_CTRL = 3'h2;
  localparam logic [2:0] LD_MIDI = 3'h3;
  localparam logic [6:0] CTRL_PWR_OFF = 7'h00;
  localparam logic [6:0] CTRL_JOY_OFF = 7'h01;
  localparam logic [6:0] CTRL_RES_OFF = 7'h02;
  localparam logic [6:0] MIDI_DATA_OFF = 7'h00;
  localparam logic [6:0] MIDI_STAT_OFF = 7'h01;
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [7:0] JOY_RATE_RST = 8'h00;
  typedef enum logic [1:0] {ST_INIT, ST_LOAD, ST_READY} ild_state_e;
endpackage

// >>> logic/ild_stream_if.sv
// Valid/ready byte stream between the front end and its queues.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface ild_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // ild_stream_if

// >>> sim/ild_host_model.sv
// Host processor and system DMA controller model that runs I/O and DMA-acknowledged cycles.
// Assumes the bench resolves the data bus from the device and this model.
`timescale 1ns/100ps
module ild_host_model (
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  input wire logic dev_oe_i,
  output logic [15:0] sa_o,
  output logic aen_o,
  output logic ior_n_o,
  output logic iow_n_o,
  output logic [7:0] sd_o,
  output logic [2:0] dack_n_o
);
  // ----------------------------------------
  // One strobed bus cycle
  // ----------------------------------------
  initial begin
    {sa_o, aen_o, ior_n_o, iow_n_o, sd_o, dack_n_o} = {16'hffff, 1'b0, 1'b1, 1'b1, 8'hff, 3'h7};
  end
  // Released address and data lines carry the inverse of their last value, so a stale byte is never mistaken for live data.
  task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic rd, input logic [2:0] dk,
                       input logic ae, output logic [7:0] q, output logic oe);
    sa_o <= a;
    sd_o <= d;
    dack_n_o <= dk;
    aen_o <= ae;
    @(posedge clk_i);
    ior_n_o <= !rd;
    iow_n_o <= rd;
    repeat (3) @(posedge clk_i);
    q = bus_i;
    oe = dev_oe_i;
    ior_n_o <= 1'b1;
    iow_n_o <= 1'b1;
    @(posedge clk_i);
    sa_o <= ~a;
    sd_o <= ~d;
    dack_n_o <= 3'h7;
    aen_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule // ild_host_model

// >>> sim/ild_host_port_tb.sv
// Self-checking bench for the host-port front end with shortened init and load counts.
// Assumes the host model owns all bus strobes and the bench owns the configuration pins.
`timescale 1ns/100ps
module ild_host_port_tb;
  localparam int INIT = 20;
  localparam int CMIN = 10;
  localparam int CMAX = 40;
  typedef struct packed {logic [15:0] a; logic [7:0] d;} ild_row_s;
  localparam ild_row_s ROWS [3] = '{'{16'h0120, 8'h5a}, '{16'h0121, 8'h3c}, '{16'h0122, 8'hc3}};
  logic clock, resetn, hrst, aen, ior_n, iow_n, sd_oe, dec16, dma_release_timing_bit, func_wr, func_rd, func_alt, joy_fire, oe;
  logic res_stb, mem_present, load_done, cfg_load, cfg_timeout, ready, tx_valid, tx_ready, rx_valid, rx_ready;
  logic [15:0] sa;
  logic [7:0] host_sd, bus_sd, sd_out, data, func_rd_data, joy, power, joy_rate, res_data, tx_data, rx_data, q;
  logic [7:0] last_dma;
  logic [2:0] dack_n, drq, dma_wr, dma_rd, dma_start, func_ld;
  logic [6:0] irq, func_off;
  logic [5:0] irq_req;
  logic [4:0] ld_active;
  logic [4:0][11:0] ld_base;
  logic [4:0][6:0] ld_len;
  logic [4:0][9:0] alt_base;
  logic [4:0][3:0] alt_len;
  logic [4:0][2:0] irq_sel;
  logic [2:0][2:0] dma_ld, dma_bytes;
  logic [2:0][7:0] dma_rd_data;
  int err_total, checked, dma_cnt, stb_cnt, fire_cnt, i, n;
  assign bus_sd = sd_oe ? sd_out : host_sd;
  ild_host_port #(.INIT_CYC(INIT), .CFG_MIN_CYC(CMIN), .CFG_MAX_CYC(CMAX)) u_ild_host_port (
    .clock_i(clock), .resetn_i(resetn), .host_reset_drive_i(hrst), .sa_i(sa), .aen_i(aen), .ior_n_i(ior_n),
    .iow_n_i(iow_n), .sd_i(bus_sd), .sd_o(sd_out), .sd_oe_o(sd_oe), .dack_n_i(dack_n), .drq_o(drq), .irq_o(irq),
    .dec16_i(dec16), .ld_active_i(ld_active), .ld_base_i(ld_base), .ld_len_i(ld_len), .ld_alt_base_i(alt_base),
    .ld_alt_len_i(alt_len), .ld_irq_sel_i(irq_sel), .irq_req_i(irq_req), .dma_release_timing_bit_i(dma_release_timing_bit),
    .dma_ld_i(dma_ld), .dma_start_i(dma_start), .dma_bytes_i(dma_bytes), .dma_rd_data_i(dma_rd_data),
    .dma_wr_o(dma_wr), .dma_rd_o(dma_rd), .data_o(data), .func_rd_data_i(func_rd_data), .func_wr_o(func_wr),
    .func_rd_o(func_rd), .func_ld_o(func_ld), .func_off_o(func_off), .func_alt_o(func_alt), .joy_i(joy),
    .joy_fire_o(joy_fire), .power_ctl_o(power), .joy_rate_o(joy_rate), .res_data_o(res_data),
    .res_data_stb_o(res_stb), .cfg_mem_present_i(mem_present), .cfg_load_done_i(load_done),
    .cfg_load_o(cfg_load), .cfg_timeout_o(cfg_timeout), .ready_o(ready), .midi_tx_data_o(tx_data),
    .midi_tx_valid_o(tx_valid), .midi_tx_ready_i(tx_ready), .midi_rx_data_i(rx_data),
    .midi_rx_valid_i(rx_valid), .midi_rx_ready_o(rx_ready));
  ild_host_model u_ild_host_model (.clk_i(clock), .bus_i(bus_sd), .dev_oe_i(sd_oe), .sa_o(sa), .aen_o(aen),
    .ior_n_o(ior_n), .iow_n_o(iow_n), .sd_o(host_sd), .dack_n_o(dack_n));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (dma_wr[0]) begin
      last_dma <= data;
      dma_cnt <= dma_cnt + 1;
    end
    if (res_stb) stb_cnt <= stb_cnt + 1;
    if (joy_fire) fire_cnt <= fire_cnt + 1;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic io(input logic [15:0] a, input logic [7:0] d, input logic rd, input logic ae);
    u_ild_host_model.cycle(a, d, rd, 3'h7, ae, q, oe);
  endtask
  task automatic dma(input logic [2:0] s);
    dma_start <= s;
    @(posedge clock);
    dma_start <= 3'h0;
    repeat (2) @(posedge clock);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // With the memory fitted, readiness follows the load handshake, or the limit when it never comes.
  task automatic wait_ready(input int done_at, input int lo, input int hi, input logic to_exp);
    load_done <= 1'b0;
    for (i = 0; i < 200 && ready !== 1'b1; i++) begin
      if (i == done_at) load_done <= 1'b1;
      @(posedge clock);
    end
    if (ready !== 1'b1) begin
      err_total++;
      print_verdict();
    end else begin
      chk("ready time", 8'h01, 8'((i >= lo) && (i <= hi)));
      chk("load timeout", {7'h0, to_exp}, {7'h0, cfg_timeout});
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {resetn, hrst, dec16, dma_release_timing_bit, mem_present, load_done, tx_ready, rx_valid, rx_data} = '0;
    {joy, func_rd_data, dma_rd_data, dma_start, irq_req, alt_base, alt_len, dma_ld} = '0;
    {err_total, checked, dma_cnt, stb_cnt, fire_cnt} = '0;
    mem_present = 1'b1;
    ld_active = 5'h0f;
    ld_base = {12'h000, 12'h330, 12'h120, 12'h201, 12'h534};
    ld_len = {7'h00, 7'h02, 7'h03, 7'h01, 7'h04};
    irq_sel = {3'h7, 3'h2, 3'h7, 3'h7, 3'h0};
    dma_bytes = {3'h1, 3'h1, 3'h2};
    repeat (6) @(posedge clock);
    chk("reset idle", 8'h00, {3'h0, ready, sd_oe, drq});
    resetn <= 1'b1;
    wait_ready(40, 41, 44, 1'b0);
    for (int k = 0; k < 3; k++) begin
      io(ROWS[k].a, ROWS[k].d, 1'b0, 1'b0);
      chk("ctrl reg", ROWS[k].d, k == 0 ? power : k == 1 ? joy_rate : res_data);
    end
    chk("res strobe", 8'h01, 8'(stb_cnt));
    io(16'h0121, 8'h00, 1'b1, 1'b0);
    chk("ctrl read", 8'h3c, q);
    joy <= 8'ha5;
    io(16'h0201, 8'h00, 1'b1, 1'b0);
    chk("joy read", 8'ha5, q);
    io(16'h0201, 8'h00, 1'b0, 1'b0);
    chk("joy fire", 8'h01, 8'(fire_cnt));
    func_rd_data <= 8'h6e;
    io(16'h0534, 8'h00, 1'b1, 1'b0);
    chk("codec read", 8'h6e, q);
    chk("codec target", 8'h00, {5'h0, func_ld});
    dec16 <= 1'b1;
    io(16'h1201, 8'h00, 1'b1, 1'b0);
    chk("upper decode", 8'h00, 8'(oe));
    dec16 <= 1'b0;
    io(16'h0731, 8'h5a, 1'b1, 1'b0);
    chk("alias drive", 8'h00, 8'(oe));
    io(16'h0120, 8'h11, 1'b0, 1'b1);
    chk("aen write", 8'h5a, power);
    ld_active <= 5'h0b;
    io(16'h0120, 8'h22, 1'b0, 1'b0);
    chk("inactive write", 8'h5a, power);
    io(16'h0121, 8'h00, 1'b1, 1'b0);
    chk("inactive drive", 8'h00, 8'(oe));
    ld_active <= 5'h0f;
    for (int k = 0; k < 17; k++) io(16'h0330, 8'(k), 1'b0, 1'b0);
    io(16'h0331, 8'h00, 1'b1, 1'b0);
    chk("midi full", 8'hc0, q);
    rx_data <= 8'h9c;
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
    io(16'h0330, 8'h00, 1'b1, 1'b0);
    chk("midi rx", 8'h9c, q);
    tx_ready <= 1'b1;
    n = 0;
    for (int j = 0; j < 40; j++) begin
      @(posedge clock);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        chk("midi tx", 8'(n), tx_data);
        n++;
      end
    end
    tx_ready <= 1'b0;
    chk("midi tx count", 8'h10, 8'(n));
    for (int t = 0; t < 2; t++) begin
      dma_release_timing_bit <= t[0];
      dma(3'h1);
      chk("drq up", 8'h01, {5'h0, drq});
      u_ild_host_model.cycle(16'h0120, 8'ha0, 1'b0, 3'h6, 1'b1, q, oe);
      chk("drq hold", 8'h01, {5'h0, drq});
      u_ild_host_model.cycle(16'h0534, 8'ha1, 1'b0, 3'h6, 1'b1, q, oe);
      chk("drq drop", 8'h00, {5'h0, drq});
      chk("dma byte", 8'ha1, last_dma);
    end
    chk("dma count", 8'h04, 8'(dma_cnt));
    chk("dma addr", 8'h5a, power);
    ld_active <= 5'h0e;
    dma(3'h1);
    chk("drq inactive", 8'h00, {5'h0, drq});
    ld_active <= 5'h0f;
    irq_req <= 6'h08;
    repeat (3) @(posedge clock);
    chk("irq midi", 8'h04, {1'b0, irq});
    irq_req <= 6'h20;
    repeat (3) @(posedge clock);
    chk("irq shared", 8'h01, {1'b0, irq});
    irq_req <= 6'h00;
    hrst <= 1'b1;
    repeat (5) @(posedge clock);
    hrst <= 1'b0;
    @(posedge clock);
    chk("host reset", 8'h00, {power[6:0], ready});
    wait_ready(999, INIT + CMAX, INIT + CMAX + 4, 1'b1);
    print_verdict();
  end
endmodule // ild_host_port_tb
